// file: hw/cable_tdr_peak_results.sv
// Cable diagnostic peak location and amplitude result bank on AHB-Lite
//
// Summary of operation
// - Word 0x181: transmit peaks four and three
// - Word 0x182: receive peak one, transmit five
// - Location word: receive peaks three and two
// - Location word: receive peaks five and four
// - Location bytes encode distance to reflection
// - Word 0x185: transmit amplitudes two and one
// - Word 0x186: transmit amplitudes four and three
// - Amplitude bits 15 and 7 read zero
// - Amplitude halves pair with matching location bytes
// - Amplitude codes encode fault type
// - Word 0x180: transmit peaks two and one
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
module cable_tdr_peak_results import tdr_results_pkg::*; (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    input  wire logic          diag_start,
    input  wire logic          diag_done,
    input  wire peak_results_t diag_results,
    output logic               diag_valid,
    output logic               irq
);
    logic          rst_meta_b;
    logic          rst_sync_b;
    bus_req_t      rd_req;
    bus_req_t      wr_req;
    peak_results_t res;
    run_state_t    run_state;
    logic          capture_en;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic          irq_int;
    logic          status_clear;
    logic          mask_write;
    logic [15:0]   rd_word;

    // Reset asserts at once but leaves on the clock so no flop sees a runt release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ahb_lite_port u_port (
        .clk    (clk),
        .rst_b  (rst_sync_b),
        .ce     (ce),
        .hsel   (hsel),
        .haddr  (haddr),
        .htrans (htrans),
        .hwrite (hwrite),
        .hsize  (hsize),
        .hready (hready),
        .rd_req (rd_req),
        .wr_req (wr_req)
    );

    assign status_clear = wr_req.sel && wr_req.idx == IDX_IRQ_STATUS;
    assign mask_write   = wr_req.sel && wr_req.idx == IDX_IRQ_MASK;

    event_irq #(.N(EVT_W)) u_irq (
        .clk      (clk),
        .rst_b    (rst_sync_b),
        .ce       (ce),
        .events   ({diag_start, diag_done}),
        .clear_en (status_clear),
        .mask_en  (mask_write),
        .wdata    (hwdata[EVT_W-1:0]),
        .status   (evt_status),
        .mask     (evt_mask),
        .irq      (irq_int)
    );

    assign irq = irq_int;

    // Software may freeze the last results while it post-processes them
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            capture_en <= CAPTURE_RESET;
        end else if (ce && wr_req.sel && wr_req.idx == IDX_RES_CTRL) begin
            capture_en <= hwdata[CTRL_CAPTURE];
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            run_state <= RUN_IDLE;
        end else if (ce) begin
            unique case (run_state)
                RUN_IDLE: begin
                    if (diag_start && !diag_done) begin
                        run_state <= RUN_BUSY;
                    end
                end
                RUN_BUSY: begin
                    if (diag_done) begin
                        run_state <= RUN_IDLE;
                    end
                end
            endcase
        end
    end

    // Whole result set is taken in one edge so no word mixes two runs
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            res <= '0;
        end else if (ce && diag_done && capture_en) begin
            res <= diag_results;
        end
    end

    // Valid rises on the done edge, which is the capture edge while capture is enabled; with capture off it rises over the held results
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            diag_valid <= 1'b0;
        end else if (ce) begin
            if (diag_done) begin
                diag_valid <= 1'b1;
            end else if (diag_start) begin
                diag_valid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_word = '0;
        unique case (rd_req.idx)
            IDX_TX_LOC_1_2: rd_word = loc_word(res.tx_loc[1], res.tx_loc[0]);
            IDX_TX_LOC_3_4: rd_word = loc_word(res.tx_loc[3], res.tx_loc[2]);
            IDX_RX1_TX5:    rd_word = loc_word(res.rx_loc[0], res.tx_loc[4]);
            IDX_RX_LOC_2_3: rd_word = loc_word(res.rx_loc[2], res.rx_loc[1]);
            IDX_RX_LOC_4_5: rd_word = loc_word(res.rx_loc[4], res.rx_loc[3]);
            IDX_TX_AMP_1_2: rd_word = amp_word(res.tx_amp[1], res.tx_amp[0]);
            IDX_TX_AMP_3_4: rd_word = amp_word(res.tx_amp[3], res.tx_amp[2]);
            IDX_IRQ_STATUS: rd_word = {{(16-EVT_W){1'b0}}, evt_status};
            IDX_IRQ_MASK:   rd_word = {{(16-EVT_W){1'b0}}, evt_mask};
            IDX_RES_CTRL:   rd_word = {15'h0000, capture_en};
            IDX_RES_STATE:  rd_word = {14'h0000, run_state == RUN_BUSY, diag_valid};
            default:        rd_word = RESULT_RESET;
        endcase
    end

    // Read data is registered at the address phase, giving zero wait states.
    // A read straight after a write sees the value from before that write.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hrdata <= '0;
        end else if (ce && hready) begin
            hrdata <= rd_req.sel ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Helper state for checks
    logic [IDX_W-1:0] chk_idx;
    logic             chk_rd;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            chk_idx <= '0;
            chk_rd  <= 1'b0;
        end else if (ce && hready) begin
            chk_idx <= rd_req.idx;
            chk_rd  <= rd_req.sel;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    sequence s_done_capture;
        ce && diag_done && capture_en;
    endsequence

    sequence s_quiet;
        ce && !diag_done;
    endsequence

    property p_capture_all;
        s_done_capture |=> res == $past(diag_results);
    endproperty
    a_capture_all: assert property (p_capture_all)
        else $error("results not captured on done");

    property p_hold_results;
        s_quiet |=> $stable(res);
    endproperty
    a_hold_results: assert property (p_hold_results)
        else $error("results changed without done");

    property p_valid_with_data;
        s_done_capture |=> diag_valid && res.tx_amp == $past(diag_results.tx_amp);
    endproperty
    a_valid_with_data: assert property (p_valid_with_data)
        else $error("valid raised without matching data");

    property p_amp_pad_zero;
        chk_rd && (chk_idx == IDX_TX_AMP_1_2 || chk_idx == IDX_TX_AMP_3_4)
            |-> !hrdata[AMP_HI_PAD] && !hrdata[AMP_LO_PAD];
    endproperty
    a_amp_pad_zero: assert property (p_amp_pad_zero)
        else $error("amplitude pad bit read as one");

    property p_tx34_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_TX_LOC_3_4 && !diag_done
            |=> hrdata[15:0] == {res.tx_loc[3], res.tx_loc[2]};
    endproperty
    a_tx34_pairing: assert property (p_tx34_pairing)
        else $error("tx peak 3/4 word misordered");

    property p_rx1_tx5_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_RX1_TX5 && !diag_done
            |=> hrdata[15:0] == {res.rx_loc[0], res.tx_loc[4]};
    endproperty
    a_rx1_tx5_pairing: assert property (p_rx1_tx5_pairing)
        else $error("rx1/tx5 word misordered");

    property p_amp12_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_TX_AMP_1_2 && !diag_done
            |=> hrdata[14:8] == res.tx_amp[1] && hrdata[6:0] == res.tx_amp[0];
    endproperty
    a_amp12_pairing: assert property (p_amp12_pairing)
        else $error("amplitude 1/2 fields misplaced");

    // Checked one cycle after the address phase, when no capture can intervene
    property p_tx12_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_TX_LOC_1_2 && !diag_done
            |=> hrdata[15:0] == {res.tx_loc[1], res.tx_loc[0]};
    endproperty
    a_tx12_pairing: assert property (p_tx12_pairing)
        else $error("tx peak 1/2 word misordered");

    property p_rx23_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_RX_LOC_2_3 && !diag_done
            |=> hrdata[15:0] == {res.rx_loc[2], res.rx_loc[1]};
    endproperty
    a_rx23_pairing: assert property (p_rx23_pairing)
        else $error("rx peak 2/3 word misordered");

    property p_rx45_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_RX_LOC_4_5 && !diag_done
            |=> hrdata[15:0] == {res.rx_loc[4], res.rx_loc[3]};
    endproperty
    a_rx45_pairing: assert property (p_rx45_pairing)
        else $error("rx peak 4/5 word misordered");

    property p_amp34_pairing;
        ce && hready && rd_req.sel && rd_req.idx == IDX_TX_AMP_3_4 && !diag_done
            |=> hrdata[14:8] == res.tx_amp[3] && hrdata[6:0] == res.tx_amp[2];
    endproperty
    a_amp34_pairing: assert property (p_amp34_pairing)
        else $error("amplitude 3/4 fields misplaced");

    property p_start_clears_valid;
        ce && diag_start && !diag_done |=> !diag_valid && run_state == RUN_BUSY;
    endproperty
    a_start_clears_valid: assert property (p_start_clears_valid)
        else $error("start left valid set or state idle");

    // An event must win over a write-one-to-clear in the same cycle
    property p_done_sets_status;
        ce && diag_done |=> evt_status[EVT_DONE];
    endproperty
    a_done_sets_status: assert property (p_done_sets_status)
        else $error("done event lost");

    property p_start_sets_status;
        ce && diag_start |=> evt_status[EVT_START];
    endproperty
    a_start_sets_status: assert property (p_start_sets_status)
        else $error("start event lost");

    // The interrupt flop is loaded from next status and mask, so it tracks them every cycle
    property p_irq_level;
        irq == |(evt_status & evt_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status");

    property p_okay;
        hresp == 1'b0 ##1 hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("error response driven");
endmodule

// file: hw/tdr_results_pkg.sv
// Shared constants, register map and types for the cable diagnostic result bank
package tdr_results_pkg;
    localparam int LOC_W      = 8;
    localparam int AMP_W      = 7;
    localparam int NUM_PEAKS  = 5;
    localparam int NUM_AMPS   = 4;
    localparam int IDX_W      = 9;
    localparam int ADDR_LSB   = 2;
    localparam int HI_LSB     = 8;
    localparam int LO_LSB     = 0;
    localparam int AMP_HI_PAD = 15;
    localparam int AMP_LO_PAD = 7;
    localparam int EVT_W      = 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_TX_LOC_1_2 = 9'h180;
    localparam logic [IDX_W-1:0] IDX_TX_LOC_3_4 = 9'h181;
    localparam logic [IDX_W-1:0] IDX_RX1_TX5    = 9'h182;
    localparam logic [IDX_W-1:0] IDX_RX_LOC_2_3 = 9'h183;
    localparam logic [IDX_W-1:0] IDX_RX_LOC_4_5 = 9'h184;
    localparam logic [IDX_W-1:0] IDX_TX_AMP_1_2 = 9'h185;
    localparam logic [IDX_W-1:0] IDX_TX_AMP_3_4 = 9'h186;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 9'h190;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 9'h191;
    localparam logic [IDX_W-1:0] IDX_RES_CTRL   = 9'h192;
    localparam logic [IDX_W-1:0] IDX_RES_STATE  = 9'h193;

    localparam int EVT_DONE       = 0;
    localparam int EVT_START      = 1;
    localparam int CTRL_CAPTURE   = 0;
    localparam int STATE_VALID    = 0;
    localparam int STATE_BUSY     = 1;

    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic        CAPTURE_RESET = 1'b1;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;

    typedef struct packed {
        logic [NUM_PEAKS-1:0][LOC_W-1:0] tx_loc;
        logic [NUM_PEAKS-1:0][LOC_W-1:0] rx_loc;
        logic [NUM_AMPS-1:0][AMP_W-1:0]  tx_amp;
    } peak_results_t;

    typedef struct packed {
        logic             sel;
        logic [IDX_W-1:0] idx;
    } bus_req_t;

    typedef enum logic {RUN_IDLE, RUN_BUSY} run_state_t;

    function automatic logic [15:0] loc_word(input logic [LOC_W-1:0] hi,
                                             input logic [LOC_W-1:0] lo);
        return {hi, lo};
    endfunction

    function automatic logic [15:0] amp_word(input logic [AMP_W-1:0] hi,
                                             input logic [AMP_W-1:0] lo);
        return {1'b0, hi, 1'b0, lo};
    endfunction
endpackage

// file: hw/ahb_lite_port.sv
// AHB-Lite address decode: read request in address phase, write in data phase
`timescale 1ns/1ns
module ahb_lite_port import tdr_results_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    output bus_req_t         rd_req,
    output bus_req_t         wr_req
);
    logic take;

    // Only aligned whole-word transfers inside the bank window are decoded
    assign take = hsel && hready && htrans[1] && hsize == HSIZE_WORD
                  && haddr[ADDR_LSB-1:0] == '0 && haddr[31:IDX_W+ADDR_LSB] == '0;

    assign rd_req.sel = take && !hwrite;
    assign rd_req.idx = haddr[IDX_W+ADDR_LSB-1:ADDR_LSB];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_req <= '0;
        end else if (ce && hready) begin
            wr_req.sel <= take && hwrite;
            wr_req.idx <= haddr[IDX_W+ADDR_LSB-1:ADDR_LSB];
        end
    end
endmodule

// file: hw/event_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ns
module event_irq #(
    parameter int N = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [N-1:0] events,
    input  wire logic         clear_en,
    input  wire logic         mask_en,
    input  wire logic [N-1:0] wdata,
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);
    logic [N-1:0] next_status;

    // An event in the clearing cycle survives the clear
    assign next_status = (status & ~(clear_en ? wdata : '0)) | events;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else if (ce) begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask <= '0;
        end else if (ce && mask_en) begin
            mask <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(next_status & (mask_en ? wdata : mask));
        end
    end
endmodule

// file: verif/cable_tdr_peak_results_tb.sv
// Self-checking bench for the cable diagnostic peak result bank
`timescale 1ns/1ns
module cable_tdr_peak_results_tb import tdr_results_pkg::*; ;
    logic          clk;
    logic          rst_b;
    logic          ce;
    logic          hsel;
    logic [31:0]   haddr;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [2:0]    hsize;
    logic [31:0]   hwdata;
    wire           hready;
    logic          hreadyout;
    logic [31:0]   hrdata;
    logic          hresp;
    logic          diag_start;
    logic          diag_done;
    peak_results_t diag_results;
    peak_results_t p1;
    peak_results_t p2;
    logic          diag_valid;
    logic          irq;
    logic [31:0]   exp_w [7];
    logic [31:0]   rdv;
    int            miscompares;
    int            samples_checked;
    logic [IDX_W-1:0] res_idx [7] = '{IDX_TX_LOC_1_2, IDX_TX_LOC_3_4, IDX_RX1_TX5,
        IDX_RX_LOC_2_3, IDX_RX_LOC_4_5, IDX_TX_AMP_1_2, IDX_TX_AMP_3_4};

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cable_tdr_peak_results uut (.clk(clk), .rst_b(rst_b), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .diag_start(diag_start), .diag_done(diag_done), .diag_results(diag_results),
        .diag_valid(diag_valid), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A wait that runs out is a failure and ends the run at once
    task automatic timeout(input string what);
        miscompares++;
        $display("unexpected at %0t: %s timed out", $time, what);
        wrap_up();
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // Ready and read data are flops, so their mid-cycle value is what the next edge sees
    task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic r;
        int   n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {21'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 20);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge clk);
            r = hreadyout;
            rd = hrdata;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 40);
        if (r !== 1'b1)
            timeout("bus");
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, rdv);
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string s);
        bus(1'b0, idx, 32'h0, rdv);
        chk_word(rdv, exp, s);
    endtask

    task automatic chk_state(input logic v, input logic i);
        @(negedge clk);
        chk_bit(diag_valid, v, "valid");
        chk_bit(irq, i, "irq");
        chk_bit(hresp, 1'b0, "hresp");
        chk_bit(hreadyout, 1'b1, "ready");
        @(posedge clk);
    endtask

    function automatic void fill(input peak_results_t r);
        exp_w[0] = {16'h0, r.tx_loc[1], r.tx_loc[0]};
        exp_w[1] = {16'h0, r.tx_loc[3], r.tx_loc[2]};
        exp_w[2] = {16'h0, r.rx_loc[0], r.tx_loc[4]};
        exp_w[3] = {16'h0, r.rx_loc[2], r.rx_loc[1]};
        exp_w[4] = {16'h0, r.rx_loc[4], r.rx_loc[3]};
        exp_w[5] = {16'h0, 1'b0, r.tx_amp[1], 1'b0, r.tx_amp[0]};
        exp_w[6] = {16'h0, 1'b0, r.tx_amp[3], 1'b0, r.tx_amp[2]};
    endfunction

    function automatic peak_results_t pattern(input logic [7:0] b);
        peak_results_t r;
        for (int i = 0; i < NUM_PEAKS; i++) begin
            r.tx_loc[i] = b + 8'(i);
            r.rx_loc[i] = (b ^ 8'hF0) + 8'(i);
        end
        for (int i = 0; i < NUM_AMPS; i++)
            r.tx_amp[i] = b[6:0] ^ 7'(7'h7F - i);
        return r;
    endfunction

    // Every result word, in table order
    task automatic check_all(input string s);
        for (int i = 0; i < 7; i++)
            rd_chk(res_idx[i], exp_w[i], s);
    endtask

    task automatic pulse(input logic start);
        if (start)
            diag_start <= 1'b1;
        else
            diag_done <= 1'b1;
        @(posedge clk);
        // Drop only the strobe raised here, so a following pulse never double-drives
        if (start)
            diag_start <= 1'b0;
        else
            diag_done <= 1'b0;
    endtask

    task automatic t_reset();
        int n;
        n = 0;
        while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (hreadyout !== 1'b1)
            timeout("reset release");
        chk_state(1'b0, 1'b0);
        fill('0);
        check_all("reset word");
        rd_chk(IDX_RES_CTRL, 32'h1, "ctrl reset");
        rd_chk(IDX_IRQ_MASK, 32'h0, "mask reset");
        rd_chk(9'h187, 32'h0, "unmapped");
    endtask

    task automatic t_run();
        diag_results <= p1;
        pulse(1'b1);
        chk_state(1'b0, 1'b0);
        rd_chk(IDX_RES_STATE, 32'h2, "busy");
        pulse(1'b0);
        chk_state(1'b1, 1'b0);
        // Stale engine outputs must not leak in without a done
        diag_results <= p2;
        fill(p1);
        check_all("run word");
        rd_chk(IDX_RES_STATE, 32'h1, "valid state");
    endtask

    task automatic t_ro();
        for (int i = 0; i < 7; i++) begin
            wr(res_idx[i], 32'hFFFF_FFFF);
            rd_chk(res_idx[i], exp_w[i], "after write");
        end
    endtask

    task automatic t_irq();
        rd_chk(IDX_IRQ_STATUS, 32'h3, "status");
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk_state(1'b1, 1'b1);
        wr(IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk_state(1'b1, 1'b0);
        rd_chk(IDX_IRQ_STATUS, 32'h2, "status cleared");
    endtask

    task automatic t_hold();
        wr(IDX_RES_CTRL, 32'h0);
        pulse(1'b1);
        pulse(1'b0);
        chk_state(1'b1, 1'b1);
        check_all("capture off");
        wr(IDX_RES_CTRL, 32'h1);
        pulse(1'b1);
        ce <= 1'b0;
        pulse(1'b0);
        ce <= 1'b1;
        // Done flag of the capture-off run is still set and unmasked, so irq stays high
        chk_state(1'b0, 1'b1);
        pulse(1'b0);
        chk_state(1'b1, 1'b1);
        fill(p2);
        check_all("second run");
    endtask

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        diag_start = 1'b0;
        diag_done = 1'b0;
        diag_results = '0;
        miscompares = 0;
        samples_checked = 0;
        p1 = pattern(8'hA5);
        p2 = pattern(8'h3C);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_run();
        t_ro();
        t_irq();
        t_hold();
        wrap_up();
    end
endmodule
